/* pkg/parser_consts.svh */
`ifndef PARSER_CONSTS_SVH
`define PARSER_CONSTS_SVH
// packet byte offsets
`define OFS_DST      8'd0
`define OFS_SRC      8'd1
`define OFS_CMD      8'd2
`define OFS_STS      8'd3
`define OFS_TNS_LO   8'd4
`define OFS_TNS_HI   8'd5
`define OFS_FNC      8'd6
`define OFS_PRM      8'd7
`define OFS_POFS_LO  8'd7
`define OFS_POFS_HI  8'd8
`define OFS_ADR      8'd11
`define HDR_LEN      9'd6
// command and function codes
`define CMD_REQ      8'h0f
`define CMD_RPL_BIT  8'h40
`define FNC_WRD_RD   8'h01
`define FNC_PHYS_WR  8'h18
`define FNC_UPL_ALL  8'h53
`define FNC_UPL_DONE 8'h55
`define FNC_TYP_WR   8'h67
// completion and extended codes
`define STS_OK       8'h00
`define STS_NOBUF    8'h01
`define STS_BADCMD   8'h10
`define STS_EXT      8'hf0
`define EXT_NONE     8'h00
`define EXT_BADSIZE  8'h07
`define EXT_BUSY     8'h0c
`define EXT_AVAIL    8'h0d
`define EXT_NOPRIV   8'h0f
`define EXT_BADTYPE  8'h11
// limits
`define MAX_TYP_DATA 9'd240
`define TYP_LEN_MAX  ({1'b0, `OFS_ADR} + `MAX_TYP_DATA)
`define MAX_PHYS     9'd238
`define PHYS_LEN_MAX ({1'b0, `OFS_ADR} + `MAX_PHYS)
`define MAX_ASCII    6'd51
`define MAX_RD       8'hf4
// ascii address form
`define ASCII_MARK   8'h24
`define ASCII_ZERO   8'h30
`define ASCII_NINE   8'h39
`define DEC_BASE     16'h000a
// data type identifiers
`define ID_END       16'h0000
`define ID_BIT       16'h0001
`define ID_BITSTR    16'h0002
`define ID_STR       16'h0003
`define ID_INT       16'h0004
`define ID_TIMER     16'h0005
`define ID_COUNTER   16'h0006
`define ID_CTRL      16'h0007
`define ID_FLOAT     16'h0008
`define ID_ARRAY     16'h0009
`define ID_ADR       16'h000f
`define ID_BCD       16'h0010
// element sizes in bytes and words
`define SZ_WORD      16'h0002
`define SZ_TIMER     16'h000a
`define SZ_CNT       16'h0006
`define SZ_FSINGLE   16'h0004
`define SZ_FDOUBLE   16'h0008
`define W_TIMER      3'd5
`define W_CNT        3'd3
`define W_FLOAT      3'd2
`define W_ONE        3'd1
// register indices (byte address = 4 * index)
`define REG_CTRL     2'd0
`define REG_STAT     2'd1
`define REG_TYPE     2'd2
`endif

/* pkg/cp_pkg.sv */
package cp_pkg;
  typedef enum logic [2:0] {
    S_RX, S_DEC, S_ADDR, S_DESC, S_DEXT, S_CHK, S_WR, S_TX
  } fsm_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } strm_t;

  typedef struct packed {
    fsm_t        st;
    logic [8:0]  len;
    logic        ovf;
    logic [7:0]  p;
    logic [7:0]  sts;
    logic [7:0]  ext;
    logic [1:0]  mode;
    logic [1:0]  saved;
    logic        edit;
    logic        other;
    logic        upl;
    logic [15:0] id;
    logic [15:0] sz;
    logic [15:0] asz;
    logic [2:0]  idc;
    logic [2:0]  szc;
    logic [1:0]  k;
    logic        arr;
    logic [15:0] base;
    logic [5:0]  alen;
    logic        ascii;
    logic [7:0]  wa;
    logic        lane;
    logic [7:0]  rlen;
    logic [8:0]  t;
    strm_t       out;
    logic        rdy;
    logic        ack;
    logic [31:0] dat;
  } state_t;
endpackage : cp_pkg

/* rtl/typed_command_parser.sv */
// Contract
// - typed write data field at most 240 bytes
// - offset, total, size two bytes, in elements
// - address binary or ascii, ascii max 51
// - elements counted; timer five, counter three words
// - type identifiers have fixed numeric codes
// - bit7 clear: identifier in bits 4-6
// - bit7 set: bits 4-6 count identifier bytes
// - bit3 clear: item size in bits 0-2
// - bit3 set: bits 0-2 count size bytes
// - extensions low byte first, zero high bytes allowed
// - array carries inner descriptor inside its size
// - end size zero, fixed sizes, float 4/8
// - upload-all refused without privilege
// - upload-completed restores previous operating mode
// - physical write only in upload, 119 words
// - word range read: code 01, fields, word address
// - single-word read is a two-byte range read
// - read reply max 244 bytes, ext on error
// - completion code zero on success, else nonzero
//
// Local design decisions: register access over Wishbone and the address map.
`include "parser_consts.svh"
module typed_command_parser (
  input  wire logic         CLK_I,
  input  wire logic         RESET_N_I,
  input  wire logic [3:0]   ADR_I,
  input  wire logic [31:0]  DAT_I,
  output logic [31:0]       DAT_O,
  input  wire logic         WE_I,
  input  wire logic [3:0]   SEL_I,
  input  wire logic         STB_I,
  input  wire logic         CYC_I,
  output logic              ACK_O,
  input  wire cp_pkg::strm_t CMD_I,
  output logic              CMD_READY_O,
  output cp_pkg::strm_t     RPL_O,
  input  wire logic         RPL_READY_I
);
  cp_pkg::state_t r;
  cp_pkg::state_t n;
  logic [7:0]  cbuf [256];
  logic [15:0] mem  [256];
  logic        cwe;
  logic        mwe;
  logic [7:0]  b;
  logic [7:0]  function_code;
  logic [7:0]  txb;
  logic [15:0] word;
  logic [15:0] ofs;
  logic [16:0] mg;
  logic [8:0]  tot;
  logic        dec_ok;
  logic        short;

  // byte merge into a 16-bit field; nonzero bytes above bit 15 flag
  function automatic logic [16:0] merge(input logic [15:0] v,
                                        input logic [7:0]  x,
                                        input logic [1:0]  k);
    merge = {1'b0, v};
    if (k == 2'd0)
      merge[7:0] = x;
    else if (k == 2'd1)
      merge[15:8] = x;
    else
      merge[16] = (x != 8'h00);
  endfunction : merge

  function automatic logic [2:0] wpe(input logic [15:0] id);
    case (id)
      `ID_TIMER:             wpe = `W_TIMER;
      `ID_COUNTER, `ID_CTRL: wpe = `W_CNT;
      `ID_FLOAT:             wpe = `W_FLOAT;
      default:               wpe = `W_ONE;
    endcase
  endfunction : wpe

  function automatic logic legal(input logic [15:0] id,
                                 input logic [15:0] sz);
    case (id)
      `ID_END:               legal = (sz == 16'h0000);
      `ID_INT, `ID_BCD:      legal = (sz == `SZ_WORD);
      `ID_TIMER:             legal = (sz == `SZ_TIMER);
      `ID_COUNTER, `ID_CTRL: legal = (sz == `SZ_CNT);
      `ID_FLOAT:
        legal = (sz == `SZ_FSINGLE) || (sz == `SZ_FDOUBLE);
      `ID_BIT, `ID_BITSTR, `ID_STR, `ID_ADR:
        legal = (sz != 16'h0000);
      default:               legal = 1'b0;
    endcase
  endfunction : legal

  assign b      = cbuf[r.p];
  assign function_code    = cbuf[`OFS_FNC];
  assign word   = mem[r.wa];
  assign ofs    = {cbuf[`OFS_POFS_HI], cbuf[`OFS_POFS_LO]};
  assign mg     = (r.idc != 3'd0) ? merge(r.id, b, r.k)
                                  : merge(r.sz, b, r.k);
  assign dec_ok = !r.ovf && (cbuf[`OFS_CMD] == `CMD_REQ);
  assign short  = ({1'b0, r.p} >= r.len);
  // reply length: header, ext code on an STS_EXT error, data of a good read
  assign tot = `HDR_LEN + {8'h00, r.ext != `EXT_NONE}
             + (((function_code == `FNC_WRD_RD) && (r.sts == `STS_OK))
                ? {1'b0, r.rlen} : 9'h000);

  always_comb
  begin
    case (r.t)
      {1'b0, `OFS_DST}:    txb = cbuf[`OFS_SRC];
      {1'b0, `OFS_SRC}:    txb = cbuf[`OFS_DST];
      {1'b0, `OFS_CMD}:    txb = cbuf[`OFS_CMD] | `CMD_RPL_BIT;
      {1'b0, `OFS_STS}:    txb = r.sts;
      {1'b0, `OFS_TNS_LO}: txb = cbuf[`OFS_TNS_LO];
      {1'b0, `OFS_TNS_HI}: txb = cbuf[`OFS_TNS_HI];
      default:
        txb = (r.ext != `EXT_NONE) ? r.ext
            : (r.lane ? word[15:8] : word[7:0]);
    endcase
  end

  always_comb
  begin
    n   = r;
    cwe = 1'b0;
    mwe = 1'b0;
    // wishbone slave: ack one cycle after the strobe, dropped next cycle
    n.ack = CYC_I && STB_I && !r.ack;
    if (CYC_I && STB_I && !r.ack)
    begin
      case (ADR_I[3:2])
        `REG_CTRL:
        begin
          n.dat = {28'h0000000, r.other, r.edit, r.mode};
          if (WE_I && SEL_I[0])
            {n.other, n.edit, n.mode} = DAT_I[3:0];
        end
        `REG_STAT: n.dat = {8'h00, r.ext, r.sts, 5'h00, r.saved, r.upl};
        `REG_TYPE: n.dat = {r.sz, r.id};
        default:   n.dat = 32'h00000000;
      endcase
    end
    unique case (r.st)
      cp_pkg::S_RX:
      begin
        n.rdy = 1'b1;
        if (r.rdy && CMD_I.valid)
        begin
          if (r.len[8])
            n.ovf = 1'b1;
          else
          begin
            cwe   = 1'b1;
            n.len = r.len + 9'h001;
          end
          if (CMD_I.last)
          begin
            n.rdy = 1'b0;
            n.st  = cp_pkg::S_DEC;
          end
        end
      end
      cp_pkg::S_DEC:
      begin
        n.sts   = `STS_OK;
        n.ext   = `EXT_NONE;
        n.arr   = 1'b0;
        n.base  = 16'h0000;
        n.alen  = 6'h00;
        n.ascii = 1'b0;
        n.rlen  = 8'h00;
        n.lane  = 1'b0;
        n.p     = `OFS_ADR;
        n.st    = cp_pkg::S_TX;
        if (r.ovf)
          n.sts = `STS_NOBUF;
        else if (!dec_ok)
          n.sts = `STS_BADCMD;
        else
        begin
          case (function_code)
            `FNC_UPL_ALL:
              if (r.mode[1] || r.edit || r.other)
              begin
                n.sts = `STS_EXT;
                n.ext = `EXT_NOPRIV;
              end
              else if (r.upl)
              begin
                n.sts = `STS_EXT;
                n.ext = `EXT_BUSY;
              end
              else
              begin
                n.saved = r.mode;
                n.upl   = 1'b1;
              end
            `FNC_UPL_DONE:
              if (!r.upl)
              begin
                n.sts = `STS_EXT;
                n.ext = `EXT_AVAIL;
              end
              else
              begin
                n.mode = r.saved;
                n.upl  = 1'b0;
              end
            `FNC_PHYS_WR:
              if (!r.upl)
              begin
                n.sts = `STS_EXT;
                n.ext = `EXT_NOPRIV;
              end
              else if (r.len > `PHYS_LEN_MAX || !r.len[0])
              begin
                n.sts = `STS_EXT;
                n.ext = `EXT_BADSIZE;
              end
              else
              begin
                n.wa = cbuf[`OFS_PRM];
                n.st = cp_pkg::S_WR;
              end
            `FNC_WRD_RD, `FNC_TYP_WR: n.st = cp_pkg::S_ADDR;
            default: n.sts = `STS_BADCMD;
          endcase
        end
      end
      cp_pkg::S_ADDR:
      begin
        n.p    = r.p + 8'h01;
        n.alen = r.alen + 6'h01;
        if (short)
        begin
          n.sts = `STS_EXT;
          n.ext = `EXT_BADSIZE;
          n.st  = cp_pkg::S_TX;
        end
        else if (r.ascii)
        begin
          if (b == 8'h00)
            n.st = (function_code == `FNC_WRD_RD) ? cp_pkg::S_CHK : cp_pkg::S_DESC;
          else if (r.alen > `MAX_ASCII)
          begin
            n.sts = `STS_EXT;
            n.ext = `EXT_BADSIZE;
            n.st  = cp_pkg::S_TX;
          end
          else if (b >= `ASCII_ZERO && b <= `ASCII_NINE)
            n.base = r.base * `DEC_BASE + {8'h00, b - `ASCII_ZERO};
        end
        else if (r.alen == 6'h00)
        begin
          if (b == `ASCII_MARK)
            n.ascii = 1'b1;
          else
            n.base[7:0] = b;
        end
        else
        begin
          n.base[15:8] = b;
          n.st = (function_code == `FNC_WRD_RD) ? cp_pkg::S_CHK : cp_pkg::S_DESC;
        end
      end
      cp_pkg::S_DESC:
      begin
        n.p   = r.p + 8'h01;
        n.k   = 2'd0;
        n.idc = b[7] ? b[6:4] : 3'd0;
        n.id  = b[7] ? 16'h0000 : {13'h0000, b[6:4]};
        n.szc = b[3] ? b[2:0] : 3'd0;
        n.sz  = b[3] ? 16'h0000 : {13'h0000, b[2:0]};
        n.st  = cp_pkg::S_DEXT;
        if (short)
        begin
          n.sts = `STS_EXT;
          n.ext = `EXT_BADSIZE;
          n.st  = cp_pkg::S_TX;
        end
      end
      cp_pkg::S_DEXT:
      begin
        if (r.idc != 3'd0 || r.szc != 3'd0)
        begin
          // identifier bytes first, then size bytes
          n.p = r.p + 8'h01;
          if (r.idc != 3'd0)
          begin
            n.id  = mg[15:0];
            n.idc = r.idc - 3'd1;
            n.k   = (r.idc == 3'd1) ? 2'd0
                  : ((r.k == 2'd3) ? r.k : r.k + 2'd1);
          end
          else
          begin
            n.sz  = mg[15:0];
            n.szc = r.szc - 3'd1;
            n.k   = (r.k == 2'd3) ? r.k : r.k + 2'd1;
          end
          if (mg[16] || short)
          begin
            n.sts = `STS_EXT;
            n.ext = `EXT_BADTYPE;
            n.st  = cp_pkg::S_TX;
          end
        end
        else if (r.id == `ID_ARRAY && !r.arr)
        begin
          n.arr = 1'b1;
          n.asz = r.sz;
          n.st  = cp_pkg::S_DESC;
        end
        else
          n.st = cp_pkg::S_CHK;
      end
      cp_pkg::S_CHK:
      begin
        n.st = cp_pkg::S_TX;
        if (function_code == `FNC_WRD_RD)
        begin
          if (short || b > `MAX_RD || b == 8'h00)
          begin
            n.sts = `STS_EXT;
            n.ext = `EXT_BADSIZE;
          end
          else
          begin
            n.rlen = b;
            n.wa   = 8'(r.base + ofs);
          end
        end
        else if (r.len > `TYP_LEN_MAX)
        begin
          n.sts = `STS_EXT;
          n.ext = `EXT_BADSIZE;
        end
        else if (!legal(r.id, r.sz) ||
                 (r.arr && r.asz <= {8'h00, r.p} - 16'(`OFS_ADR)))
        begin
          n.sts = `STS_EXT;
          n.ext = `EXT_BADTYPE;
        end
        else
        begin
          n.wa = 8'(r.base + ofs * {13'h0000, wpe(r.id)});
          n.st = cp_pkg::S_WR;
        end
      end
      cp_pkg::S_WR:
      begin
        // data bytes pair into words, low byte first
        if (!short)
        begin
          mwe    = 1'b1;
          n.p    = r.p + 8'h01;
          n.lane = !r.lane;
          if (r.lane)
            n.wa = r.wa + 8'h01;
        end
        else
        begin
          n.lane = 1'b0;
          n.st   = cp_pkg::S_TX;
        end
      end
      cp_pkg::S_TX:
        if (!r.out.valid || RPL_READY_I)
        begin
          if (r.t == tot)
          begin
            n.out.valid = 1'b0;
            n.out.last  = 1'b0;
            n.t   = 9'h000;
            n.len = 9'h000;
            n.ovf = 1'b0;
            n.rdy = 1'b1;
            n.st  = cp_pkg::S_RX;
          end
          else
          begin
            n.out.valid = 1'b1;
            n.out.data  = txb;
            n.out.last  = (r.t + 9'h001 == tot);
            n.t = r.t + 9'h001;
            if (r.t >= `HDR_LEN && r.ext == `EXT_NONE)
            begin
              n.lane = !r.lane;
              if (r.lane)
                n.wa = r.wa + 8'h01;
            end
          end
        end
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
      r <= '0;
    else
      r <= n;
  end

  always_ff @(posedge CLK_I)
  begin
    if (cwe)
      cbuf[r.len[7:0]] <= CMD_I.data;
    if (mwe && r.lane)
      mem[r.wa][15:8] <= b;
    if (mwe && !r.lane)
      mem[r.wa][7:0] <= b;
  end

  assign DAT_O       = r.dat;
  assign ACK_O       = r.ack;
  assign CMD_READY_O = r.rdy;
  assign RPL_O       = r.out;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  a_upload_priv: assert property (
    (r.st == cp_pkg::S_DEC && dec_ok && function_code == `FNC_UPL_ALL && r.mode[1])
    |=> (r.sts == `STS_EXT && r.ext == `EXT_NOPRIV))
    else $error("upload-all accepted in run mode");
  a_upload_back: assert property (
    (r.st == cp_pkg::S_DEC && dec_ok && function_code == `FNC_UPL_DONE && r.upl)
    |=> (r.mode == $past(r.saved) && !r.upl))
    else $error("mode not restored after upload");
  a_phys_perm: assert property (
    (mwe && function_code == `FNC_PHYS_WR) |-> r.upl)
    else $error("physical write outside upload mode");
  a_read_cap: assert property (
    (r.st == cp_pkg::S_TX && function_code == `FNC_WRD_RD) |-> r.rlen <= `MAX_RD)
    else $error("read reply too long");
  a_fail_code: assert property (
    (r.st == cp_pkg::S_TX && r.ext != `EXT_NONE) |-> r.sts != `STS_OK)
    else $error("error reply with zero completion code");
  a_node_swap: assert property (
    (r.out.valid && r.t == 9'h001) |-> r.out.data == cbuf[`OFS_SRC])
    else $error("reply destination is not command source");
  a_reply_code: assert property (
    (r.out.valid && r.t == 9'h003)
    |-> r.out.data == (cbuf[`OFS_CMD] | `CMD_RPL_BIT))
    else $error("reply code lacks bit 6");
  a_desc_id: assert property (
    (r.st == cp_pkg::S_DESC && !short && !b[7])
    |=> r.id == {13'h0000, $past(b[6:4])} && r.idc == 3'd0)
    else $error("direct identifier misdecoded");
  a_desc_size: assert property (
    (r.st == cp_pkg::S_DESC && !short && !b[3])
    |=> r.sz == {13'h0000, $past(b[2:0])})
    else $error("direct size misdecoded");
  a_typed_len: assert property (
    (r.st == cp_pkg::S_WR && function_code == `FNC_TYP_WR) |-> r.len <= `TYP_LEN_MAX)
    else $error("typed write data field over limit");
  a_ack_pulse: assert property (
    ACK_O |=> !ACK_O)
    else $error("ack held longer than one cycle");
endmodule : typed_command_parser

/* tb/host_model.sv */
module host_model (
  input  wire logic          clk_i,
  input  wire logic          cmd_ready_i,
  input  wire cp_pkg::strm_t rpl_i,
  output cp_pkg::strm_t      cmd_o,
  output logic               rpl_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pkt [0:299];
  logic [7:0] rx  [$];
  logic       tmo = 1'b0;
  logic       slow = 1'b0;
  initial
  begin
    cmd_o       = '0;
    rpl_ready_o = 1'b0;
  end
  // bytes leave in packet order, fields low byte first
  task send(input int n);
    int   i;
    int   k;
    logic r;
    rx.delete();
    for (i = 0; i < n; i++)
    begin
      cmd_o <= '{valid: 1'b1, last: (i == n - 1), data: pkt[i]};
      k = 0;
      do
      begin
        @(posedge clk_i);
        r = cmd_ready_i;
        k++;
      end while (!r && k < 300);
      if (!r) tmo = 1'b1;
    end
    // idle data is scrambled so no stale byte looks valid
    cmd_o <= '{valid: 1'b0, last: 1'b0, data: ~pkt[n - 1]};
    k = 0;
    r = 1'b0;
    while (!r && k < 2000)
    begin
      rpl_ready_o <= slow ? ~rpl_ready_o : 1'b1;
      @(posedge clk_i);
      if (rpl_i.valid && rpl_ready_o)
      begin
        rx.push_back(rpl_i.data);
        r = rpl_i.last;
      end
      k++;
    end
    rpl_ready_o <= 1'b0;
    if (!r) tmo = 1'b1;
  endtask : send
endmodule : host_model

/* tb/tb_typed_command_parser.sv */
module tb_typed_command_parser;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  logic [3:0]    adr = 4'h0;
  logic [31:0]   wdat = 32'h0;
  logic [31:0]   rdat;
  logic          we = 1'b0;
  logic          cyc = 1'b0;
  logic          stb = 1'b0;
  logic [3:0]    sel = 4'h0;
  logic [3:0]    wsel = 4'hf;
  logic          ack;
  cp_pkg::strm_t cmd;
  cp_pkg::strm_t rpl;
  logic          cmd_ready;
  logic          rpl_ready;
  logic [31:0]   q;
  logic [7:0]    tag = 8'h00;
  int            errors = 0;
  int            n_tests = 0;
  int            n = 0;
  always #2 clk = ~clk;
  typed_command_parser u_typed_command_parser (
    .CLK_I(clk), .RESET_N_I(rst_n), .ADR_I(adr), .DAT_I(wdat),
    .DAT_O(rdat), .WE_I(we), .SEL_I(sel), .STB_I(stb), .CYC_I(cyc),
    .ACK_O(ack), .CMD_I(cmd), .CMD_READY_O(cmd_ready), .RPL_O(rpl),
    .RPL_READY_I(rpl_ready));
  host_model u_host_model (.clk_i(clk), .cmd_ready_i(cmd_ready),
    .rpl_i(rpl), .cmd_o(cmd), .rpl_ready_o(rpl_ready));
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task chk(input string what, input logic [31:0] seen,
           input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      errors++;
    end
  endtask : chk
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int   k;
    logic ak;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= wsel;
    adr  <= a;
    wdat <= d;
    k  = 0;
    ak = 1'b0;
    while (!ak && k < 50)
    begin
      @(posedge clk);
      ak = ack;
      if (ak)
        q = rdat;
      k++;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    sel <= 4'h0;
    if (!ak)
    begin
      chk("wb ack", 1'b0, 1'b1);
      report_and_stop;
    end
  endtask : wb
  function automatic logic [7:0] rb(input int i);
    return u_host_model.rx[i];
  endfunction : rb
  task put(input logic [7:0] b);
    u_host_model.pkt[n] = b;
    n++;
  endtask : put
  task put16(input logic [15:0] v);
    put(v[7:0]);
    put(v[15:8]);
  endtask : put16
  task start(input logic [7:0] function_code);
    tag = tag + 8'h01;
    n   = 0;
    put(8'h05);
    put(8'h2a);
    put(8'h0f);
    put(8'h00);
    put(tag);
    put(8'h5a);
    put(function_code);
  endtask : start
  // len below zero: any failing completion code accepted
  task go(input logic [7:0] sts, input int len);
    u_host_model.send(n);
    if (u_host_model.tmo)
    begin
      chk("host wait", 1'b0, 1'b1);
      report_and_stop;
    end
    chk("rpl dst", rb(0), 8'h2a);
    chk("rpl src", rb(1), 8'h05);
    chk("rpl cmd", rb(2), 8'h4f);
    chk("rpl tag", {rb(5), rb(4)}, {8'h5a, tag});
    if (len < 0)
      chk("rpl fail", rb(3) == 8'h00, 1'b0);
    else
    begin
      chk("rpl sts", rb(3), sts);
      chk("rpl len", u_host_model.rx.size(), len);
    end
  endtask : go
  task goe(input logic [7:0] ext);
    go(8'hf0, 7);
    chk("rpl ext", rb(6), ext);
  endtask : goe
  task wread(input logic [15:0] a, input logic [7:0] sz);
    start(8'h01);
    put16(16'h0000);
    put16({8'h00, sz});
    put16(a);
    put(sz);
  endtask : wread
  task twr(input logic [15:0] ofs, input logic [15:0] cnt,
           input logic [15:0] a);
    start(8'h67);
    put16(ofs);
    put16(cnt);
    put16(a);
  endtask : twr
  task t_regs;
    wb(1'b0, 4'h0, 32'h0);
    chk("ctrl rst", q, 32'h0);
    wb(1'b0, 4'h4, 32'h0);
    chk("stat rst", q, 32'h0);
    wb(1'b1, 4'hc, 32'hffffffff);
    wb(1'b0, 4'hc, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(1'b1, 4'h0, 32'h1);
    wb(1'b0, 4'h0, 32'h0);
    chk("ctrl rw", q[3:0], 4'h1);
    // low byte lane off: the control write must be ignored
    wsel = 4'he;
    wb(1'b1, 4'h0, 32'h2);
    wsel = 4'hf;
    wb(1'b0, 4'h0, 32'h0);
    chk("ctrl sel", q[3:0], 4'h1);
    $display("done t_regs");
  endtask : t_regs
  task t_upload;
    start(8'h18);
    put(8'h40);
    put16(16'h0000);
    put(8'h00);
    put16(16'hbeef);
    go(8'h00, -1);
    start(8'h53);
    go(8'h00, 6);
    wb(1'b0, 4'h4, 32'h0);
    chk("stat upl", q[2:0], 3'b011);
    start(8'h53);
    goe(8'h0c);
    start(8'h18);
    put(8'h40);
    put16(16'h0000);
    put(8'h00);
    put16(16'hbeef);
    put16(16'h0123);
    u_host_model.slow = 1'b1;
    go(8'h00, 6);
    u_host_model.slow = 1'b0;
    wread(16'h0040, 8'h04);
    go(8'h00, 10);
    chk("phys data", {rb(9), rb(8), rb(7), rb(6)}, 32'h0123beef);
    // mode moved during upload so the restore has to bring it back
    wb(1'b1, 4'h0, 32'h0);
    start(8'h55);
    go(8'h00, 6);
    wb(1'b0, 4'h0, 32'h0);
    chk("mode back", q[1:0], 2'h1);
    start(8'h55);
    goe(8'h0d);
    $display("done t_upload");
  endtask : t_upload
  task t_nopriv;
    logic [31:0] v [4] = '{32'h2, 32'h3, 32'h5, 32'h9};
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, 4'h0, v[i]);
      start(8'h53);
      goe(8'h0f);
      wb(1'b0, 4'h4, 32'h0);
      chk("no upl", q[0], 1'b0);
    end
    wb(1'b1, 4'h0, 32'h0);
    $display("done t_nopriv");
  endtask : t_nopriv
  task t_typed;
    logic [23:0] dsc [4] = '{24'h000042, 24'h000492, 24'h0004a2,
                             24'h000249};
    int          dl  [4] = '{1, 2, 3, 2};
    for (int i = 0; i < 4; i++)
    begin
      if (i == 2)
      begin
        twr(16'h0000, 16'h0001, 16'h0000);
        n = 11;
        put(8'h24);
        put(8'h31);
        put(8'h38);
        put(8'h00);
      end
      else
        twr(16'h0000, 16'h0001, 16'h0010 + 16'(i));
      for (int j = 0; j < dl[i]; j++)
        put(dsc[i][8*j +: 8]);
      put16(16'h1230 + 16'(i));
      go(8'h00, 6);
      wb(1'b0, 4'h8, 32'h0);
      chk("type reg", q, 32'h00020004);
    end
    wread(16'h0010, 8'h08);
    go(8'h00, 14);
    for (int j = 0; j < 4; j++)
      chk("int word", {rb(7+2*j), rb(6+2*j)}, 16'h1230 + 16'(j));
    twr(16'h0001, 16'h0001, 16'h0020);
    put(8'h59);
    put(8'h0a);
    for (int j = 0; j < 5; j++)
      put16(16'ha000 + 16'(j));
    go(8'h00, 6);
    wb(1'b0, 4'h8, 32'h0);
    chk("timer type", q, 32'h000a0005);
    wread(16'h0025, 8'h0a);
    go(8'h00, 16);
    for (int j = 0; j < 5; j++)
      chk("timer word", {rb(7+2*j), rb(6+2*j)}, 16'ha000 + 16'(j));
    twr(16'h0000, 16'h0003, 16'h0030);
    put(8'h97);
    put(8'h09);
    put(8'h42);
    put16(16'h0000);
    put16(16'hfffe);
    put16(16'h00ff);
    go(8'h00, 6);
    wread(16'h0030, 8'h06);
    go(8'h00, 12);
    chk("array", {rb(11), rb(10), rb(9), rb(8)}, 32'h00fffffe);
    twr(16'h0000, 16'h0001, 16'h0050);
    put(8'h43);
    put16(16'h0000);
    put(8'h00);
    goe(8'h11);
    for (int lim = 251; lim < 253; lim++)
    begin
      twr(16'h0000, 16'(lim - 14), 16'h0050);
      put(8'h31);
      while (n < lim)
        put(8'h00);
      if (lim == 251)
        go(8'h00, 6);
      else
        goe(8'h07);
    end
    $display("done t_typed");
  endtask : t_typed
  task t_read;
    wread(16'h0040, 8'h02);
    go(8'h00, 8);
    chk("one word", {rb(7), rb(6)}, 16'hbeef);
    wread(16'h0040, 8'hf4);
    go(8'h00, 250);
    wread(16'h0040, 8'h00);
    goe(8'h07);
    wread(16'h0040, 8'hf5);
    goe(8'h07);
    start(8'h77);
    go(8'h10, 6);
    $display("done t_read");
  endtask : t_read
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_upload;
    t_nopriv;
    t_typed;
    t_read;
    report_and_stop;
  end
endmodule : tb_typed_command_parser
